//--- design/brc_counters.sv
`timescale 1ns/10ps
// What this block does
// - count detected bit errors, readable by software
// - 24-bit error count, bytes at 94h-96h
// - error count saturates at all ones
// - no error counting while sync lost
// - count every received bit separately
// - 32-bit bit count, bytes 98h-9Bh
// - bit count saturates at all ones
// - hold bit count while sync lost
// - snapshot: copy, clear, zero low, done
// - done forced low when request drops
// - sync-lost status reflects checker lock
// - error-present status: count nonzero
module brc_counters
	import brc_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	input  wire logic              rx_line_clk_i,
	input  wire logic              rx_bit_error_i,
	input  wire logic              pattern_sync_lost_i,
	output logic                   irq_o
);

	function automatic logic [BITS_W-1:0] sat_inc(
		input logic [BITS_W-1:0] value,
		input logic [BITS_W-1:0] limit,
		input logic              step
	);
		logic [BITS_W-1:0] res;
		res = value;
		if (step && (value != limit)) begin
			res = value + 32'h0000_0001;
		end
		return res;
	endfunction : sat_inc

	// exact 8-bit match, so a stray address never aliases onto a control register
	function automatic logic wr_hit(
		input logic              wr,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs
	);
		return wr && (addr == ofs);
	endfunction : wr_hit

	localparam logic [BITS_W-1:0] ERR_MAX  = {{(BITS_W-ERR_W){1'b0}}, {ERR_W{1'b1}}};
	localparam logic [BITS_W-1:0] BITS_MAX = {BITS_W{1'b1}};

	// ---- link inputs, resynchronised
	logic [2:0] link_s;
	logic       line_clk_s;
	logic       bit_error_s;
	logic       sync_lost_s;

	brc_sync2 #(
		.W (3)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.async_i   ({rx_line_clk_i, rx_bit_error_i, ~pattern_sync_lost_i}),
		.sync_o    (link_s)
	);

	assign line_clk_s  = link_s[2];
	assign bit_error_s = link_s[1];
	// carried inverted so the chain's reset value means lost, as the idle pin does
	assign sync_lost_s = ~link_s[0];

	logic line_clk_prev_q;
	logic line_clk_prev_d;
	logic bit_strobe;
	logic count_ok;
	logic error_hit;

	// data and clock share the sync path, so they stay aligned at the edge
	assign bit_strobe = line_clk_s & ~line_clk_prev_q;
	assign count_ok   = bit_strobe & ~sync_lost_s;
	assign error_hit  = count_ok & bit_error_s;

	always_comb begin
		line_clk_prev_d = line_clk_s;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			line_clk_prev_q <= 1'b0;
		end else begin
			line_clk_prev_q <= line_clk_prev_d;
		end
	end

	// ---- control register
	logic snap_req_q;
	logic snap_req_d;
	logic snap_req_prev_q;
	logic snap_req_prev_d;
	logic snap_rise;

	assign snap_rise = snap_req_q & ~snap_req_prev_q;

	always_comb begin
		snap_req_d      = snap_req_q;
		snap_req_prev_d = snap_req_q;
		if (wr_hit(reg_wr_i, reg_addr_i, OFS_CTRL)) begin
			snap_req_d = reg_wdata_i[CTRL_REQ_BIT];
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			snap_req_q      <= 1'b0;
			snap_req_prev_q <= 1'b0;
		end else begin
			snap_req_q      <= snap_req_d;
			snap_req_prev_q <= snap_req_prev_d;
		end
	end

	// ---- live tallies, snapshot and sequence
	brc_tally_t      live_q;
	brc_tally_t      live_d;
	brc_tally_t      snap_q;
	brc_tally_t      snap_d;
	brc_snap_state_t state_q;
	brc_snap_state_t state_d;
	logic            done_q;
	logic            done_d;
	logic [BITS_W-1:0] err_next;
	logic [BITS_W-1:0] bits_next;

	always_comb begin
		err_next  = sat_inc({{(BITS_W-ERR_W){1'b0}}, live_q.errors}, ERR_MAX, error_hit);
		bits_next = sat_inc(live_q.bits, BITS_MAX, count_ok);
		live_d    = live_q;
		snap_d    = snap_q;
		state_d   = state_q;
		done_d    = done_q;
		live_d.errors = err_next[ERR_W-1:0];
		live_d.bits   = bits_next;
		unique case (state_q)
			SNAP_IDLE: begin
				if (snap_rise) begin
					// this cycle's bit lands in the fresh tally, so none is lost
					snap_d        = live_q;
					live_d.errors = {{(ERR_W-1){1'b0}}, error_hit};
					live_d.bits   = {{(BITS_W-1){1'b0}}, count_ok};
					done_d        = 1'b0;
					state_d       = SNAP_ZERO;
				end
			end
			SNAP_ZERO: begin
				done_d  = 1'b1;
				state_d = SNAP_IDLE;
			end
			// the two spare codes of the state word fall back to idle
			default: begin
				state_d = SNAP_IDLE;
			end
		endcase
		if (!snap_req_q) begin
			done_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			live_q  <= '0;
			snap_q  <= '0;
			state_q <= SNAP_IDLE;
			done_q  <= 1'b0;
		end else begin
			live_q  <= live_d;
			snap_q  <= snap_d;
			state_q <= state_d;
			done_q  <= done_d;
		end
	end

	// ---- status
	logic done_stat;
	logic present_stat;
	logic done_prev_q;
	logic done_prev_d;
	logic present_prev_q;
	logic present_prev_d;
	logic lost_prev_q;
	logic lost_prev_d;

	// gating with the request makes the drop visible in the same cycle
	assign done_stat    = done_q & snap_req_q;
	assign present_stat = (live_q.errors != '0) && (state_q != SNAP_ZERO);

	// ---- interrupt status, clear and enable
	brc_evt_t evt_now;
	brc_evt_t irq_stat_q;
	brc_evt_t irq_stat_d;
	brc_evt_t irq_en_q;
	brc_evt_t irq_en_d;

	always_comb begin
		done_prev_d    = done_stat;
		present_prev_d = present_stat;
		lost_prev_d    = sync_lost_s;
		evt_now.done_rise    = done_stat & ~done_prev_q;
		evt_now.error_seen   = error_hit;
		evt_now.present_rise = present_stat & ~present_prev_q;
		evt_now.sync_change  = sync_lost_s ^ lost_prev_q;
		irq_stat_d = irq_stat_q;
		irq_en_d   = irq_en_q;
		if (wr_hit(reg_wr_i, reg_addr_i, OFS_IRQ_CLEAR)) begin
			irq_stat_d = irq_stat_q & ~brc_evt_t'(reg_wdata_i[3:0]);
		end
		if (wr_hit(reg_wr_i, reg_addr_i, OFS_IRQ_ENABLE)) begin
			irq_en_d = brc_evt_t'(reg_wdata_i[3:0]);
		end
		// a new event beats a clear in the same cycle
		irq_stat_d = irq_stat_d | evt_now;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_prev_q    <= 1'b0;
			present_prev_q <= 1'b0;
			lost_prev_q    <= 1'b1;
			irq_stat_q     <= RST_EVT;
			irq_en_q       <= RST_EVT;
		end else begin
			done_prev_q    <= done_prev_d;
			present_prev_q <= present_prev_d;
			lost_prev_q    <= lost_prev_d;
			irq_stat_q     <= irq_stat_d;
			irq_en_q       <= irq_en_d;
		end
	end

	assign irq_o = |(irq_stat_q & irq_en_q);

	// ---- register read; counter bytes have no write path at all
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = RST_BYTE;
		unique case (reg_addr_i)
			OFS_CTRL: begin
				rd_mux[CTRL_REQ_BIT] = snap_req_q;
			end
			OFS_STATUS: begin
				rd_mux[STAT_LOST_BIT]    = sync_lost_s;
				rd_mux[STAT_PRESENT_BIT] = present_stat;
				rd_mux[STAT_DONE_BIT]    = done_stat;
			end
			OFS_IRQ_STATUS: begin
				rd_mux[3:0] = irq_stat_q;
			end
			OFS_IRQ_ENABLE: begin
				rd_mux[3:0] = irq_en_q;
			end
			OFS_ERR_B0: begin
				rd_mux = snap_q.errors[7:0];
			end
			OFS_ERR_B1: begin
				rd_mux = snap_q.errors[15:8];
			end
			OFS_ERR_B2: begin
				rd_mux = snap_q.errors[23:16];
			end
			OFS_BITS_B0: begin
				rd_mux = snap_q.bits[7:0];
			end
			OFS_BITS_B1: begin
				rd_mux = snap_q.bits[15:8];
			end
			OFS_BITS_B2: begin
				rd_mux = snap_q.bits[23:16];
			end
			OFS_BITS_B3: begin
				rd_mux = snap_q.bits[31:24];
			end
			default: begin
				rd_mux = RST_BYTE;
			end
		endcase
		rdata_d = reg_rd_i ? rd_mux : RST_BYTE;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

endmodule : brc_counters

//--- design/brc_pkg.sv
package brc_pkg;

	localparam int unsigned ERR_W  = 24;
	localparam int unsigned BITS_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFS_CTRL       = 8'hA0;
	localparam logic [7:0] OFS_STATUS     = 8'hA1;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'hA2;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'hA3;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'hA4;
	localparam logic [7:0] OFS_ERR_B0     = 8'h94;
	localparam logic [7:0] OFS_ERR_B1     = 8'h95;
	localparam logic [7:0] OFS_ERR_B2     = 8'h96;
	localparam logic [7:0] OFS_BITS_B0    = 8'h98;
	localparam logic [7:0] OFS_BITS_B1    = 8'h99;
	localparam logic [7:0] OFS_BITS_B2    = 8'h9A;
	localparam logic [7:0] OFS_BITS_B3    = 8'h9B;

	// field positions
	localparam int unsigned CTRL_REQ_BIT     = 0;
	localparam int unsigned STAT_LOST_BIT    = 0;
	localparam int unsigned STAT_PRESENT_BIT = 1;
	localparam int unsigned STAT_DONE_BIT    = 3;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_EVT  = 4'h0;

	// interrupt event layout, bit 3 first
	typedef struct packed {
		logic done_rise;
		logic error_seen;
		logic present_rise;
		logic sync_change;
	} brc_evt_t;

	typedef struct packed {
		logic [BITS_W-1:0] bits;
		logic [ERR_W-1:0]  errors;
	} brc_tally_t;

	typedef enum logic [1:0] {
		SNAP_IDLE,
		SNAP_ZERO
	} brc_snap_state_t;

endpackage : brc_pkg

//--- design/brc_sync2.sv
`timescale 1ns/10ps
module brc_sync2
	import brc_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// the first stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule : brc_sync2

//--- verification/brc_counters_monitor.sv
`timescale 1ns/10ps
module brc_counters_monitor
	import brc_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [DATA_W-1:0] reg_rdata_o,
	input  wire logic              rx_line_clk_i,
	input  wire logic              rx_bit_error_i,
	input  wire logic              pattern_sync_lost_i,
	input  wire logic              irq_o
);
	logic       req_q;
	logic [3:0] en_q;
	logic       seen_q;
	logic       err_q;
	wire        wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
	wire        rd_stat = reg_rd_i && reg_addr_i == OFS_STATUS;
	// loose shadows: they only ever widen what the design may show
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_q  <= 1'b0;
			en_q   <= 4'h0;
			seen_q <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			if (wr_ctrl) req_q <= reg_wdata_i[CTRL_REQ_BIT];
			if (reg_wr_i && reg_addr_i == OFS_IRQ_ENABLE) en_q <= reg_wdata_i[3:0];
			if (!pattern_sync_lost_i) seen_q <= 1'b1;
			if (!pattern_sync_lost_i && rx_bit_error_i) err_q <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == RST_BYTE; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped; reg_rd_i && reg_addr_i == 8'h97 |=> reg_rdata_o == RST_BYTE; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_done_low; rd_stat && !req_q |=> !reg_rdata_o[STAT_DONE_BIT]; endproperty
	a_done_low: assert property (p_done_low) else $error("done without request");
	property p_done_high;
		wr_ctrl && reg_wdata_i[CTRL_REQ_BIT] && !req_q ##1 !wr_ctrl [*3] ##1 rd_stat
			|=> reg_rdata_o[STAT_DONE_BIT];
	endproperty
	a_done_high: assert property (p_done_high) else $error("snapshot done late");
	property p_pre_sync;
		reg_rd_i && !seen_q && reg_addr_i[7:4] == 4'h9 |=> reg_rdata_o == RST_BYTE;
	endproperty
	a_pre_sync: assert property (p_pre_sync) else $error("count without sync");
	property p_sync_stat;
		$stable(pattern_sync_lost_i) [*6] ##0 rd_stat
			|=> reg_rdata_o[STAT_LOST_BIT] == $past(pattern_sync_lost_i);
	endproperty
	a_sync_stat: assert property (p_sync_stat) else $error("sync status wrong");
	property p_irq_off; en_q == 4'h0 |-> !irq_o; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while all masked");
	property p_present; rd_stat && !err_q |=> !reg_rdata_o[STAT_PRESENT_BIT]; endproperty
	a_present: assert property (p_present) else $error("error present w/o error");
endmodule : brc_counters_monitor

bind brc_counters brc_counters_monitor u_mon (
	.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .rx_line_clk_i(rx_line_clk_i),
	.rx_bit_error_i(rx_bit_error_i), .pattern_sync_lost_i(pattern_sync_lost_i),
	.irq_o(irq_o)
);

//--- verification/brc_line_model.sv
`timescale 1ns/10ps
module brc_line_model (
	output logic line_clk_o,
	output logic bit_err_o
);
	initial begin
		line_clk_o = 1'b0;
		bit_err_o  = 1'b0;
	end
	// bit i is a mismatch when emask[i%32]; the clock stands low between frames
	task automatic send(input int n, input logic [31:0] emask);
		for (int i = 0; i < n; i++) begin
			bit_err_o = emask[i%32];
			#62.5 line_clk_o = 1'b1;
			#62.5 line_clk_o = 1'b0;
		end
		// stale flag must not look like a held value
		bit_err_o = ~bit_err_o;
	endtask : send
endmodule : brc_line_model

//--- verification/tb.sv
`timescale 1ns/10ps
module tb
	import brc_pkg::*;
;
	logic              clk_sys_i   = 1'b0;
	logic              reset_n_i   = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i  = 8'h00;
	logic [DATA_W-1:0] reg_wdata_i = 8'h00;
	logic              reg_wr_i    = 1'b0;
	logic              reg_rd_i    = 1'b0;
	logic              sync_lost   = 1'b1;
	logic [DATA_W-1:0] reg_rdata_o;
	logic              line_clk;
	logic              bit_err;
	logic              irq_o;
	logic [31:0]       seed        = 32'h000119E9;
	int                err_total   = 0;
	int                checks_done = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	brc_counters uut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .rx_line_clk_i(line_clk), .rx_bit_error_i(bit_err),
		.pattern_sync_lost_i(sync_lost), .irq_o(irq_o)
	);
	brc_line_model u_line (.line_clk_o(line_clk), .bit_err_o(bit_err));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int exp_err(int n, logic [31:0] m);
		int c = 0;
		for (int i = 0; i < n; i++) c += m[i%32];
		return c;
	endfunction : exp_err
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic snap(output logic [23:0] e, output logic [31:0] b);
		logic [7:0] d = 8'h00;
		wr(OFS_CTRL, 8'h01);
		repeat (8) if (!d[STAT_DONE_BIT]) rd(OFS_STATUS, d);
		chk(d[STAT_DONE_BIT], 1);
		for (int i = 0; i < 3; i++) begin
			rd(OFS_ERR_B0 + 8'(i), d);
			e[8*i+:8] = d;
		end
		for (int i = 0; i < 4; i++) begin
			rd(OFS_BITS_B0 + 8'(i), d);
			b[8*i+:8] = d;
		end
		wr(OFS_CTRL, 8'h00);
		rd(OFS_STATUS, d);
		chk(d[STAT_DONE_BIT], 0);
	endtask : snap
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#400us;
		err_total++;
		end_of_test();
	end
	initial begin
		logic [7:0]  d;
		logic [23:0] e;
		logic [31:0] b;
		logic [31:0] m;
		int          n;
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(OFS_ERR_B0 + 8'(i), d);
			chk(d, 0);
		end
		wr(OFS_ERR_B1, 8'(rnd()));
		wr(OFS_BITS_B0, 8'(rnd()));
		rd(OFS_STATUS, d);
		chk(d[STAT_LOST_BIT], 1);
		u_line.send(20, 32'hFFFFFFFF);
		repeat (6) @(posedge clk_sys_i);
		snap(e, b);
		chk(e, 0);
		chk(b, 0);
		wr(OFS_IRQ_ENABLE, 8'h04);
		sync_lost <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		for (int k = 0; k < 3; k++) begin
			n = 1 + rnd() % 300;
			m = rnd() | 32'h00000001;
			u_line.send(n, m);
			repeat (6) @(posedge clk_sys_i);
			rd(OFS_STATUS, d);
			chk(d[STAT_PRESENT_BIT], 1);
			chk(d[STAT_LOST_BIT], 0);
			snap(e, b);
			chk(e, exp_err(n, m));
			chk(b, n);
			rd(OFS_STATUS, d);
			chk(d[STAT_PRESENT_BIT], 0);
		end
		wr(OFS_BITS_B0, 8'(rnd()));
		wr(OFS_ERR_B2, 8'(rnd()));
		rd(OFS_BITS_B0, d);
		chk(d, b[7:0]);
		rd(OFS_ERR_B2, d);
		chk(d, e[23:16]);
		chk(irq_o, 1);
		wr(OFS_IRQ_CLEAR, 8'h0F);
		#1 chk(irq_o, 0);
		wr(OFS_IRQ_ENABLE, 8'h00);
		u_line.send(4, 32'h0000000F);
		repeat (6) @(posedge clk_sys_i);
		#1 chk(irq_o, 0);
		wr(OFS_IRQ_ENABLE, 8'h04);
		#1 chk(irq_o, 1);
		// reset in mid-run: snapshots hold counts, so zero after it means something
		reset_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(OFS_ERR_B0 + 8'(i), d);
			chk(d, 0);
		end
		chk(irq_o, 0);
		end_of_test();
	end
endmodule : tb
